// file: rtl/subb_swap_pkg.sv
package subb_swap_pkg;

  // Instruction word layout.
  localparam int INSTR_W      = 16;
  localparam int OPC_HI       = 15;
  localparam int OPC_LO       = 10;
  localparam int DEST_BIT     = 9;
  localparam int BANK_BIT     = 8;
  localparam int FADDR_HI     = 7;
  localparam int FADDR_LO     = 0;

  // Upper six opcode bits of the two instructions handled here.
  localparam logic [5:0] OPC_SUB_BORROW = 6'h16;
  localparam logic [5:0] OPC_NIBBLE_SWAP = 6'h0E;

  // Destination and bank bit meanings.
  localparam logic DEST_ACC     = 1'h0;
  localparam logic BANK_ACCESS  = 1'h0;

  // Address map constants.
  localparam int         DADDR_W        = 12;
  localparam logic [7:0] ACCESS_SPLIT   = 8'h80;
  localparam logic [7:0] INDEXED_LIMIT  = 8'h5F;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

  // Status flag positions.
  localparam int STAT_W   = 5;
  localparam int STAT_C   = 0;
  localparam int STAT_DC  = 1;
  localparam int STAT_Z   = 2;
  localparam int STAT_OV  = 3;
  localparam int STAT_N   = 4;

  // Reset values.
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [11:0] ADDR_RST  = 12'h000;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [4:0]  STAT_RST  = 5'h00;

  // Four phases of one instruction cycle, plus idle.
  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_DECODE  = 3'b001,
    PH_READ    = 3'b010,
    PH_PROCESS = 3'b011,
    PH_WRITE   = 3'b100
  } phase_t;

endpackage : subb_swap_pkg

// file: rtl/operand_addr_resolve.sv
`timescale 1ns/1ns
module operand_addr_resolve (
  // Addressing fields.
  input  wire logic       bank_sel,
  input  wire logic [7:0] file_addr,
  // Core context.
  input  wire logic [3:0] bank_select_register,
  input  wire logic       ext_set_en,
  input  wire logic [11:0] index_base,
  // Resolved data memory address.
  output logic [11:0]     data_addr,
  output logic            indexed
);

  // Pick access bank, banked or indexed literal offset address.
  always_comb begin
    indexed   = 1'b0;
    data_addr = {subb_swap_pkg::ACCESS_LO_BANK, file_addr};
    if (bank_sel != subb_swap_pkg::BANK_ACCESS) begin
      data_addr = {bank_select_register, file_addr};
    end else if (ext_set_en && file_addr <= subb_swap_pkg::INDEXED_LIMIT) begin
      indexed   = 1'b1;
      data_addr = index_base + {4'h0, file_addr};
    end else if (file_addr >= subb_swap_pkg::ACCESS_SPLIT) begin
      data_addr = {subb_swap_pkg::ACCESS_HI_BANK, file_addr};
    end
  end

endmodule : operand_addr_resolve

// file: rtl/subb_swap_exec.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Subtract-with-borrow computes f minus W minus not-C.
// - Destination bit picks accumulator or file register.
// - Bank bit picks access bank or banked.
// - Extended set, low address: indexed literal offset.
// - Nibble swap exchanges upper and lower nibbles.
// - Swap destination bit picks accumulator or register.
module subb_swap_exec (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Instruction issue from the decoder.
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  // Core context.
  input  wire logic [7:0]  acc_value,
  input  wire logic [4:0]  status_in,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic        ext_set_en,
  input  wire logic [11:0] index_base,
  // Data memory port.
  output logic [11:0]      mem_addr,
  output logic             mem_rd,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_we,
  output logic [7:0]       mem_wdata,
  // Accumulator and status write-back.
  output logic             acc_we,
  output logic [7:0]       acc_wdata,
  output logic             status_we,
  output logic [4:0]       status_out,
  // Sequencing.
  output logic             busy,
  output logic             done,
  output logic             reject,
  output logic             indexed_access
);

  // Latched instruction, operand and datapath intermediates.
  subb_swap_pkg::phase_t phase_reg;
  logic [15:0] instr_reg;
  logic [7:0]  operand_reg;
  logic [7:0]  result_next;
  logic [4:0]  flags_next;
  logic [11:0] addr_res;
  logic        idx_res;
  logic [5:0]  opc;
  logic        is_sub;
  logic        dest_reg_sel;
  logic [8:0]  diff_full;
  logic [4:0]  diff_low;
  logic [7:0]  diff;

  //////////////////////////////////////////////////////////////////////////
  // True for the two opcodes this datapath executes. Anything else is
  // refused in the decode phase, so the core can hand it to another unit.
  // The same test steers the sequencer, the busy flag and the read strobe.
  function automatic logic is_handled_op(input logic [5:0] code);
    is_handled_op = (code == subb_swap_pkg::OPC_SUB_BORROW) ||
                    (code == subb_swap_pkg::OPC_NIBBLE_SWAP);
  endfunction : is_handled_op

  //////////////////////////////////////////////////////////////////////////
  // Field decode of the latched instruction.
  assign opc          = instr_reg[subb_swap_pkg::OPC_HI:subb_swap_pkg::OPC_LO];
  assign is_sub       = (opc == subb_swap_pkg::OPC_SUB_BORROW);
  assign dest_reg_sel = (instr_reg[subb_swap_pkg::DEST_BIT] != subb_swap_pkg::DEST_ACC);

  // Operand address resolution.
  operand_addr_resolve u_addr (
    .bank_sel             (instr_reg[subb_swap_pkg::BANK_BIT]),
    .file_addr            (instr_reg[subb_swap_pkg::FADDR_HI:subb_swap_pkg::FADDR_LO]),
    .bank_select_register (bank_select_register),
    .ext_set_en           (ext_set_en),
    .index_base           (index_base),
    .data_addr            (addr_res),
    .indexed              (idx_res)
  );

  // Subtraction as f plus inverted W plus carry; carry out means no borrow.
  // One adder serves the result and the carry flag; a narrow copy of the low
  // nibble gives the digit carry without a second full-width subtractor.
  // subtract with borrow.
  assign diff_full = {1'b0, operand_reg} + {1'b0, ~acc_value}
                   + {8'h00, status_in[subb_swap_pkg::STAT_C]};
  assign diff_low  = {1'b0, operand_reg[3:0]} + {1'b0, ~acc_value[3:0]}
                   + {4'h0, status_in[subb_swap_pkg::STAT_C]};
  assign diff      = diff_full[7:0];

  //////////////////////////////////////////////////////////////////////////
  // Phase sequencer: decode, read, process, write.
  // An opcode this unit does not execute drops back to idle after decode,
  // so the core is never held up by an instruction meant for another unit.
  // four phase cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= subb_swap_pkg::PH_IDLE;
    end else begin
      case (phase_reg)
        subb_swap_pkg::PH_IDLE: begin
          if (instr_valid) begin
            phase_reg <= subb_swap_pkg::PH_DECODE;
          end
        end
        subb_swap_pkg::PH_DECODE: begin
          if (is_handled_op(opc)) begin
            phase_reg <= subb_swap_pkg::PH_READ;
          end else begin
            phase_reg <= subb_swap_pkg::PH_IDLE;
          end
        end
        subb_swap_pkg::PH_READ:    phase_reg <= subb_swap_pkg::PH_PROCESS;
        subb_swap_pkg::PH_PROCESS: phase_reg <= subb_swap_pkg::PH_WRITE;
        default:                   phase_reg <= subb_swap_pkg::PH_IDLE;
      endcase
    end
  end

  // Instruction latch and busy flag.
  // The latch loads only in idle, so an issue strobe while busy is ignored
  // and cannot disturb the instruction in flight.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      instr_reg <= subb_swap_pkg::INSTR_RST;
      busy      <= 1'b0;
    end else begin
      if (phase_reg == subb_swap_pkg::PH_IDLE && instr_valid) begin
        instr_reg <= instr_word;
      end
      busy <= (phase_reg == subb_swap_pkg::PH_IDLE) ? instr_valid
            : !(phase_reg == subb_swap_pkg::PH_WRITE ||
                (phase_reg == subb_swap_pkg::PH_DECODE && !is_handled_op(opc)));
    end
  end

  // Refusal pulse for an opcode this unit does not execute. Without it the
  // core would wait for a completion that never comes.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reject <= 1'b0;
    end else begin
      reject <= (phase_reg == subb_swap_pkg::PH_DECODE) && !is_handled_op(opc);
    end
  end

  // Address presentation and operand read.
  // The address is registered at the end of decode, so it is steady for the
  // whole read phase and the memory sees no change while it answers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr       <= subb_swap_pkg::ADDR_RST;
      mem_rd         <= 1'b0;
      indexed_access <= 1'b0;
      operand_reg    <= subb_swap_pkg::BYTE_RST;
    end else begin
      mem_rd <= (phase_reg == subb_swap_pkg::PH_DECODE) && is_handled_op(opc);
      if (phase_reg == subb_swap_pkg::PH_DECODE) begin
        mem_addr       <= addr_res;
        indexed_access <= idx_res;
      end
      // Read data is taken only in the read phase, while the strobe stands.
      if (phase_reg == subb_swap_pkg::PH_READ) begin
        operand_reg <= mem_rdata;
      end
    end
  end

  // Process phase: form the result and the new flags from the operand read
  // in the previous phase. Kept combinational so that the edge ending this
  // phase registers them straight into the outputs, in one instruction cycle.
  always_comb begin
    result_next = {operand_reg[3:0], operand_reg[7:4]};
    flags_next  = status_in;
    if (is_sub) begin
      result_next = diff;
      flags_next[subb_swap_pkg::STAT_C]  = diff_full[8];
      flags_next[subb_swap_pkg::STAT_DC] = diff_low[4];
      flags_next[subb_swap_pkg::STAT_Z]  = (diff == subb_swap_pkg::BYTE_RST);
      flags_next[subb_swap_pkg::STAT_N]  = diff[7];
      // Overflow: operands of unlike sign and a result whose sign left f's.
      flags_next[subb_swap_pkg::STAT_OV] = (operand_reg[7] != acc_value[7]) &&
                                           (diff[7] != operand_reg[7]);
    end
  end

  // Write phase: route result, update status and signal completion.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_we     <= 1'b0;
      mem_wdata  <= subb_swap_pkg::BYTE_RST;
      acc_we     <= 1'b0;
      acc_wdata  <= subb_swap_pkg::BYTE_RST;
      status_we  <= 1'b0;
      status_out <= subb_swap_pkg::STAT_RST;
      done       <= 1'b0;
    end else begin
      mem_we    <= (phase_reg == subb_swap_pkg::PH_PROCESS) && dest_reg_sel;
      acc_we    <= (phase_reg == subb_swap_pkg::PH_PROCESS) && !dest_reg_sel;
      status_we <= (phase_reg == subb_swap_pkg::PH_PROCESS) && is_sub;
      done      <= (phase_reg == subb_swap_pkg::PH_PROCESS);
      // Data and flags are registered here and hold until the next
      // instruction reaches its write phase, so the core may sample them late.
      if (phase_reg == subb_swap_pkg::PH_PROCESS) begin
        mem_wdata  <= result_next;
        acc_wdata  <= result_next;
        status_out <= flags_next;
      end
    end
  end

endmodule : subb_swap_exec

// file: verification/subb_swap_props.sv
`timescale 1ns/1ns
module subb_swap_props (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Issue and context.
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [7:0]  acc_value,
  input wire logic [4:0]  status_in,
  input wire logic [3:0]  bank_select_register,
  input wire logic        ext_set_en,
  input wire logic [11:0] index_base,
  // Results.
  input wire logic [11:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic [7:0]  mem_rdata,
  input wire logic        mem_we,
  input wire logic [7:0]  mem_wdata,
  input wire logic        acc_we,
  input wire logic [7:0]  acc_wdata,
  input wire logic        status_we,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        reject,
  input wire logic        indexed_access
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [7:0] dif;
  // Expected difference with the inverted carry taken off.
  assign dif = mem_rdata - acc_value - {7'h00, !status_in[subb_swap_pkg::STAT_C]};
  sequence s_sub;
    instr_valid && !busy && instr_word[15:10] == subb_swap_pkg::OPC_SUB_BORROW;
  endsequence
  sequence s_swp;
    instr_valid && !busy && instr_word[15:10] == subb_swap_pkg::OPC_NIBBLE_SWAP;
  endsequence
  sequence s_other;
    instr_valid && !busy && instr_word[15:10] != subb_swap_pkg::OPC_SUB_BORROW
      && instr_word[15:10] != subb_swap_pkg::OPC_NIBBLE_SWAP;
  endsequence
  a_phase_order: assert property ((s_sub or s_swp) |-> ##2 mem_rd ##2 done)
    else $error("read or write phase out of place");
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_sub_to_acc: assert property (s_sub ##0 !instr_word[9] |-> ##4 acc_we
    && !mem_we && status_we)
    else $error("subtract to accumulator misrouted");
  a_sub_value: assert property (s_sub |-> ##4 (acc_we ? acc_wdata : mem_wdata)
    == $past(dif, 2))
    else $error("subtract result wrong");
  a_swap_value: assert property (s_swp |-> ##4 !status_we && (acc_we ? acc_wdata : mem_wdata)
    == {$past(mem_rdata[3:0], 2), $past(mem_rdata[7:4], 2)})
    else $error("swap result wrong or flags written");
  a_swap_dest: assert property (s_swp ##0 instr_word[9] |-> ##4 mem_we && !acc_we)
    else $error("swap to register misrouted");
  a_bank_addr: assert property ((s_sub or s_swp) ##0 instr_word[8] |-> ##2
    mem_addr == {bank_select_register, $past(instr_word[7:0], 2)})
    else $error("banked address wrong");
  a_index_addr: assert property ((s_sub or s_swp) ##0 !instr_word[8] && ext_set_en
    && instr_word[7:0] <= 8'h5F |-> ##2 mem_addr == index_base
    + {4'h0, $past(instr_word[7:0], 2)} ##2 indexed_access)
    else $error("indexed address wrong");
  a_busy_span: assert property ((s_sub or s_swp) |=> busy [*4] ##1 !busy)
    else $error("busy span wrong");
  a_reject_pulse: assert property (s_other |-> ##2 reject && !busy ##1 !reject && !done)
    else $error("unhandled opcode not refused");
endmodule : subb_swap_props
bind subb_swap_exec subb_swap_props chk_i (.*);

// file: verification/data_mem_model.sv
`timescale 1ns/1ns
module data_mem_model (
  // Clock.
  input  wire logic        clk_sys,
  // Data memory port.
  input  wire logic [11:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_we,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] last_reg = 8'h00;
  // Data shows only in the read cycle; otherwise the line turns from the last byte.
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_reg;
  // Writes land at the edge of the write cycle.
  always @(posedge clk_sys) begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
    if (mem_rd) last_reg <= mem[mem_addr];
  end
endmodule : data_mem_model

// file: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        clk_sys, rst_n, instr_valid, ext_set_en, mem_rd, mem_we, acc_we;
  logic        status_we, busy, done, indexed_access, reject;
  logic [15:0] instr_word;
  logic [7:0]  acc_value, mem_rdata, mem_wdata, acc_wdata;
  logic [4:0]  status_in, status_out;
  logic [3:0]  bank_select_register;
  logic [11:0] index_base, mem_addr;
  int          fail_count = 0;
  int          n_tests = 0;
  subb_swap_exec dut (.*);
  data_mem_model mem_i (.*);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic issue(input logic [15:0] iw, input logic [7:0] w, input logic c);
    int k;
    @(posedge clk_sys);
    #2;
    instr_word = iw;
    acc_value = w;
    status_in = {4'h0, c};
    instr_valid = 1'b1;
    @(posedge clk_sys);
    #2;
    instr_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 8) begin
      @(posedge clk_sys);
      #2;
      k++;
    end
    chk(12'(k), 12'h003);
    if (k == 8) wrap_up();
  endtask : issue
  task automatic t_sub;
    logic [17:0] tab [4] = '{{8'h19, 8'h0D, 2'b11}, {8'h1B, 8'h1A, 2'b00},
                             {8'h03, 8'h0E, 2'b11}, {8'h80, 8'h01, 2'b10}};
    logic [7:0]  f, w, r;
    logic        c, d;
    logic [8:0]  full;
    for (int i = 0; i < 4; i++) begin
      {f, w, c, d} = tab[i];
      // Let the previous write-back land before the operand is preloaded.
      @(posedge clk_sys);
      #2;
      mem_i.mem[12'h010] = f;
      issue({subb_swap_pkg::OPC_SUB_BORROW, d, 1'b0, 8'h10}, w, c);
      full = {1'b0, f} - {1'b0, w} - {8'h00, !c};
      r = full[7:0];
      chk(d ? mem_wdata : acc_wdata, r);
      chk({mem_we, acc_we, status_we}, {d, !d, 1'b1});
      chk(status_out, {r[7], f[7] != w[7] && r[7] != f[7], r == 8'h00,
          {1'b0, f[3:0]} >= {1'b0, w[3:0]} + {4'h0, !c}, !full[8]});
    end
  endtask : t_sub
  task automatic t_swap;
    mem_i.mem[12'h020] = 8'h53;
    for (int d = 0; d < 2; d++) begin
      issue({subb_swap_pkg::OPC_NIBBLE_SWAP, d[0], 1'b0, 8'h20}, 8'h77, 1'b1);
      chk(d[0] ? mem_wdata : acc_wdata, 12'h035);
      chk(status_out, 12'h001);
      chk({mem_we, acc_we, status_we}, {d[0], !d[0], 1'b0});
    end
  endtask : t_swap
  task automatic t_addr;
    logic [22:0] tab [6] = '{{2'b10, 8'hA0, 12'h5A0, 1'b0}, {2'b00, 8'h20, 12'h020, 1'b0},
                             {2'b00, 8'h90, 12'hF90, 1'b0}, {2'b01, 8'h5F, 12'h35F, 1'b1},
                             {2'b01, 8'h60, 12'h060, 1'b0}, {2'b11, 8'h10, 12'h510, 1'b0}};
    logic        b, idx;
    logic [7:0]  f;
    logic [11:0] ea;
    for (int i = 0; i < 6; i++) begin
      {b, ext_set_en, f, ea, idx} = tab[i];
      mem_i.mem[ea] = 8'h4B;
      issue({subb_swap_pkg::OPC_NIBBLE_SWAP, 1'b0, b, f}, 8'h00, 1'b0);
      chk(mem_addr, ea);
      chk(acc_wdata, 12'h0B4);
      chk(indexed_access, idx);
      mem_i.mem[ea] = 8'h00;
    end
  endtask : t_addr
  // Unhandled opcode: one refusal pulse, no write and no completion.
  task automatic t_reject;
    int k;
    @(posedge clk_sys);
    #2;
    instr_word = {6'h3F, 2'b01, 8'h10};
    instr_valid = 1'b1;
    @(posedge clk_sys);
    #2;
    instr_valid = 1'b0;
    k = 0;
    while (reject !== 1'b1 && k < 8) begin
      @(posedge clk_sys);
      #2;
      k++;
    end
    chk(12'(k), 12'h001);
    if (k == 8) wrap_up();
    @(posedge clk_sys);
    #2;
    chk({busy, reject, done, mem_we, acc_we}, 12'h000);
  endtask : t_reject
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    acc_value = 8'h00;
    status_in = 5'h00;
    bank_select_register = 4'h5;
    ext_set_en = 1'b0;
    index_base = 12'h300;
    repeat (12) @(posedge clk_sys);
    #2;
    rst_n = 1'b1;
    t_sub();
    t_swap();
    t_addr();
    t_reject();
    wrap_up();
  end
endmodule : testbench
